// ===== csfr_bank.sv
// core register bank: indirect port, timer0, pc low byte, status, pointer, port data
// assumes the execution core gives one-hot access strobes and holds ext_rdata
// valid in the cycle ext_rd_q is high
`timescale 1ns/1ps
`default_nettype none

module csfr_bank (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic main_rd,
    input wire logic main_wr,
    input wire logic config_page_read_insn,
    input wire logic config_page_write_insn,
    input wire logic aux_page_read_insn,
    input wire logic aux_page_write_insn,
    input wire logic [6:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] ext_rdata,
    input wire logic insn_done,
    input wire logic long_jump_insn,
    input wire logic long_subroutine_insn,
    input wire logic [10:0] insn_target,
    input wire logic [2:0] pc_high_buffer,
    input wire logic flag_carry_we,
    input wire logic alu_carry,
    input wire logic flag_half_we,
    input wire logic alu_half_carry,
    input wire logic flag_zero_we,
    input wire logic alu_zero,
    input wire logic sleep_insn,
    input wire logic watchdog_kick_insn,
    input wire logic watchdog_timeout,
    input wire logic inst_tick,
    input wire logic timer0_mode_setting,
    input wire logic timer0_cfg_low_osc,
    input wire logic timer0_external_clock_pin,
    input wire logic low_osc_clk,
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_a_dir_out,
    input wire logic [5:0] port_b_pins,
    input wire logic [5:0] port_b_dir_out,
    input wire logic port_readback_option,
    output logic [7:0] rdata_q,
    output logic rd_valid_q,
    output logic ext_rd_q,
    output logic ext_wr_q,
    output logic [1:0] ext_page_q,
    output logic [8:0] ext_addr_q,
    output logic [7:0] ext_wdata_q,
    output logic [10:0] pc_q,
    output logic stack_push_q,
    output logic [10:0] stack_push_data_q,
    output logic [7:0] status_q,
    output logic [7:0] pointer_q,
    output logic [7:0] timer0_count_q,
    output logic timer0_overflow_q,
    output logic [7:0] port_a_latch_q,
    output logic [7:0] port_b_latch_q
);

    // =====================================================
    // helpers
    function automatic logic reg_hit(input logic [6:0] eff, input logic [6:0] ofs, input logic en);
        reg_hit = en && (eff == ofs);
    endfunction : reg_hit

    function automatic logic [7:0] port_read(input logic [7:0] pins, input logic [7:0] dir,
                                             input logic [7:0] latch, input logic opt);
        port_read = (~dir & pins) | (dir & (opt ? latch : pins));
    endfunction : port_read

    // =====================================================
    // access decode
    logic acc_rd;
    logic acc_wr;
    logic acc_main;
    logic acc_int;
    logic [1:0] acc_page;
    logic [6:0] eff_addr;
    logic [7:0] int_val;
    logic [7:0] port_b_view;
    logic timer_wr;
    logic pcl_wr;
    logic status_wr;
    logic pointer_wr;
    logic port_a_wr;
    logic port_b_wr;

    always_comb begin
        acc_rd = main_rd || config_page_read_insn || aux_page_read_insn; // [R1]
        acc_wr = main_wr || config_page_write_insn || aux_page_write_insn; // [R1]
        if (config_page_read_insn || config_page_write_insn) begin
            acc_page = csfr_pkg::PAGE_CONFIG; // [R1]
        end else if (aux_page_read_insn || aux_page_write_insn) begin
            acc_page = csfr_pkg::PAGE_AUX; // [R1]
        end else begin
            acc_page = csfr_pkg::PAGE_MAIN;
        end
        acc_main = (acc_page == csfr_pkg::PAGE_MAIN);
        // indirect port has no storage: swap in the pointer offset
        eff_addr = (acc_main && cpu_addr == csfr_pkg::OFS_INDIRECT) ? pointer_q[6:0] : cpu_addr; // [R3] [R16]
        acc_int = acc_main && (eff_addr < csfr_pkg::OFS_FIRST_EXT);
        timer_wr = reg_hit(eff_addr, csfr_pkg::OFS_TIMER0, acc_wr && acc_int);
        pcl_wr = reg_hit(eff_addr, csfr_pkg::OFS_PCL, acc_wr && acc_int);
        status_wr = reg_hit(eff_addr, csfr_pkg::OFS_STATUS, acc_wr && acc_int);
        pointer_wr = reg_hit(eff_addr, csfr_pkg::OFS_POINTER, acc_wr && acc_int);
        port_a_wr = reg_hit(eff_addr, csfr_pkg::OFS_PORT_A, acc_wr && acc_int);
        port_b_wr = reg_hit(eff_addr, csfr_pkg::OFS_PORT_B, acc_wr && acc_int);
        port_b_view = port_read({2'h0, port_b_pins}, {2'h0, port_b_dir_out}, port_b_latch_q,
                                port_readback_option); // [R17]
        port_b_view[7:6] = port_b_latch_q[7:6]; // [R20]
        case (eff_addr)
            csfr_pkg::OFS_TIMER0: int_val = timer0_count_q; // [R4]
            csfr_pkg::OFS_PCL: int_val = pc_q[7:0]; // [R6] [R7]
            csfr_pkg::OFS_STATUS: int_val = status_q;
            csfr_pkg::OFS_POINTER: int_val = pointer_q;
            csfr_pkg::OFS_PORT_A: int_val = port_read(port_a_pins, port_a_dir_out, port_a_latch_q,
                                                      port_readback_option); // [R17]
            csfr_pkg::OFS_PORT_B: int_val = port_b_view;
            default: int_val = 8'h00; // indirect through itself reads zero
        endcase
    end

    // =====================================================
    // read pipeline and outward access
    logic int_pend_q;
    logic int_pend_d;
    logic [7:0] int_val_q;
    logic [7:0] int_val_d;
    logic [7:0] rdata_d;
    logic rd_valid_d;
    logic ext_rd_d;
    logic ext_wr_d;
    logic [1:0] ext_page_d;
    logic [8:0] ext_addr_d;
    logic [7:0] ext_wdata_d;

    always_comb begin
        int_pend_d = acc_rd && acc_int;
        int_val_d = int_val;
        ext_rd_d = acc_rd && !acc_int;
        ext_wr_d = acc_wr && !acc_int;
        ext_page_d = acc_page;
        // bank bits only steer the main page
        ext_addr_d = acc_main ? {status_q[csfr_pkg::STAT_BANK_HI:csfr_pkg::STAT_BANK_LO], eff_addr}
                              : {2'h0, eff_addr}; // [R2] [R15] [R22]
        ext_wdata_d = cpu_wdata;
        rd_valid_d = int_pend_q || ext_rd_q;
        rdata_d = ext_rd_q ? ext_rdata : (int_pend_q ? int_val_q : rdata_q);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            int_pend_q <= 1'b0;
            int_val_q <= 8'h00;
            rdata_q <= 8'h00;
            rd_valid_q <= 1'b0;
            ext_rd_q <= 1'b0;
            ext_wr_q <= 1'b0;
            ext_page_q <= csfr_pkg::PAGE_MAIN;
            ext_addr_q <= 9'h000;
            ext_wdata_q <= 8'h00;
        end else begin
            int_pend_q <= int_pend_d;
            int_val_q <= int_val_d;
            rdata_q <= rdata_d;
            rd_valid_q <= rd_valid_d;
            ext_rd_q <= ext_rd_d;
            ext_wr_q <= ext_wr_d;
            ext_page_q <= ext_page_d;
            ext_addr_q <= ext_addr_d;
            ext_wdata_q <= ext_wdata_d;
        end
    end

    // =====================================================
    // timer0
    logic ext_pin_q;
    logic low_osc_q;
    logic t0_tick;
    logic [7:0] timer0_count_d;
    logic timer0_overflow_d;

    always_comb begin
        // slow sources count on rising edges seen at the core clock; no prescaler here
        if (timer0_mode_setting == csfr_pkg::TIMER0_MODE_INST) begin
            t0_tick = inst_tick; // [R5]
        end else if (timer0_cfg_low_osc) begin
            t0_tick = low_osc_clk && !low_osc_q; // [R5]
        end else begin
            t0_tick = timer0_external_clock_pin && !ext_pin_q; // [R5]
        end
        timer0_count_d = timer_wr ? cpu_wdata : 8'(timer0_count_q + {7'h00, t0_tick}); // [R4]
        timer0_overflow_d = !timer_wr && t0_tick && (timer0_count_q == 8'hff);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_pin_q <= 1'b0;
            low_osc_q <= 1'b0;
            timer0_count_q <= csfr_pkg::TIMER0_RST;
            timer0_overflow_q <= 1'b0;
        end else begin
            ext_pin_q <= timer0_external_clock_pin;
            low_osc_q <= low_osc_clk;
            timer0_count_q <= timer0_count_d;
            timer0_overflow_q <= timer0_overflow_d;
        end
    end

    // =====================================================
    // program counter
    logic [10:0] pc_d;
    logic stack_push_d;
    logic [10:0] stack_push_data_d;

    always_comb begin
        pc_d = pc_q;
        if (pcl_wr) begin
            pc_d = {pc_high_buffer, cpu_wdata}; // [R21] [R7]
        end else if (long_jump_insn || long_subroutine_insn) begin
            pc_d = insn_target; // [R8] [R9]
        end else if (insn_done) begin
            pc_d = 11'(pc_q + csfr_pkg::PC_STEP); // [R6]
        end
        stack_push_d = long_subroutine_insn && !pcl_wr; // [R9]
        stack_push_data_d = 11'(pc_q + csfr_pkg::PC_STEP); // [R9]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pc_q <= csfr_pkg::PC_RST;
            stack_push_q <= 1'b0;
            stack_push_data_q <= csfr_pkg::PC_RST;
        end else begin
            pc_q <= pc_d;
            stack_push_q <= stack_push_d;
            stack_push_data_q <= stack_push_data_d;
        end
    end

    // =====================================================
    // status, pointer, port latches
    logic [7:0] status_d;
    logic [7:0] pointer_d;
    logic [7:0] port_a_latch_d;
    logic [7:0] port_b_latch_d;

    always_comb begin
        status_d = status_wr ? cpu_wdata : status_q;
        // hardware events override a software write in the same cycle
        if (flag_carry_we) status_d[csfr_pkg::STAT_C] = alu_carry; // [R10]
        if (flag_half_we) status_d[csfr_pkg::STAT_DC] = alu_half_carry; // [R11]
        if (flag_zero_we) status_d[csfr_pkg::STAT_Z] = alu_zero; // [R12]
        if (watchdog_kick_insn) begin
            status_d[csfr_pkg::STAT_PD_N] = 1'b1; // [R13]
            status_d[csfr_pkg::STAT_TO_N] = 1'b1; // [R14]
        end
        if (sleep_insn) begin
            status_d[csfr_pkg::STAT_PD_N] = 1'b0; // [R13]
            status_d[csfr_pkg::STAT_TO_N] = 1'b1; // [R14]
        end
        if (watchdog_timeout) status_d[csfr_pkg::STAT_TO_N] = 1'b0; // [R14]
        pointer_d = pointer_wr ? cpu_wdata : pointer_q; // [R16]
        port_a_latch_d = port_a_wr ? cpu_wdata : port_a_latch_q; // [R18]
        port_b_latch_d = port_b_wr ? cpu_wdata : port_b_latch_q; // [R19] [R20]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= csfr_pkg::STATUS_RST; // [R13] [R14] [R15]
            pointer_q <= csfr_pkg::POINTER_RST; // [R16]
            port_a_latch_q <= csfr_pkg::PORT_RST;
            port_b_latch_q <= csfr_pkg::PORT_RST;
        end else begin
            status_q <= status_d;
            pointer_q <= pointer_d;
            port_a_latch_q <= port_a_latch_d;
            port_b_latch_q <= port_b_latch_d;
        end
    end

    // =====================================================
    // assertions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    pcl_load_a: assert property (pcl_wr |=> pc_q == {$past(pc_high_buffer), $past(cpu_wdata)}) // [R21]
        else $error("pc not loaded from buffer and written byte");
    pc_step_a: assert property (insn_done && !pcl_wr && !long_jump_insn && !long_subroutine_insn // [R6]
        |=> pc_q == 11'($past(pc_q) + csfr_pkg::PC_STEP))
        else $error("pc did not advance by one");
    jump_load_a: assert property (long_jump_insn && !pcl_wr |=> pc_q == $past(insn_target)) // [R8]
        else $error("long jump target not loaded");
    call_push_a: assert property (long_subroutine_insn && !pcl_wr // [R9]
        |=> stack_push_q && stack_push_data_q == 11'($past(pc_q) + csfr_pkg::PC_STEP))
        else $error("call did not push next address");
    timer_write_a: assert property (timer_wr |=> timer0_count_q == $past(cpu_wdata)) // [R4]
        else $error("timer write not taken");
    pd_sleep_a: assert property (sleep_insn |=> !status_q[csfr_pkg::STAT_PD_N]) // [R13]
        else $error("power-down flag not cleared by sleep");
    to_timeout_a: assert property (watchdog_timeout |=> !status_q[csfr_pkg::STAT_TO_N]) // [R14]
        else $error("timeout flag not cleared");
    zero_flag_a: assert property (flag_zero_we |=> status_q[csfr_pkg::STAT_Z] == $past(alu_zero)) // [R12]
        else $error("zero flag wrong");
    bank_ignore_a: assert property ((acc_rd || acc_wr) && !acc_main |=> ext_addr_q[8:7] == 2'h0) // [R2]
        else $error("bank bits leaked into config or aux address");
    indirect_addr_a: assert property (main_rd && cpu_addr == csfr_pkg::OFS_INDIRECT // [R22] [R3]
        && pointer_q[6:0] >= csfr_pkg::OFS_FIRST_EXT
        |=> ext_rd_q && ext_addr_q == {$past(status_q[7:6]), $past(pointer_q[6:0])})
        else $error("indirect address not bank plus pointer");
    read_lat_a: assert property (acc_rd |-> ##2 rd_valid_q) // [R4]
        else $error("read answer not two cycles later");

endmodule : csfr_bank

`default_nettype wire

// ===== csfr_bank_tb_top.sv
// self-checking bench for the core register bank
// assumes csfr_bank and csfr_ext_model are compiled first; one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

module csfr_bank_tb_top;
    logic ref_clk, rst, main_rd, main_wr, config_page_read_insn, config_page_write_insn;
    logic aux_page_read_insn, aux_page_write_insn, insn_done, long_jump_insn, long_subroutine_insn;
    logic flag_carry_we, alu_carry, flag_half_we, alu_half_carry, flag_zero_we, alu_zero;
    logic sleep_insn, watchdog_kick_insn, watchdog_timeout, inst_tick, timer0_mode_setting;
    logic timer0_cfg_low_osc, timer0_external_clock_pin, low_osc_clk, port_readback_option;
    logic rd_valid_q, ext_rd_q, ext_wr_q, stack_push_q, timer0_overflow_q;
    logic [6:0] cpu_addr;
    logic [7:0] cpu_wdata, ext_rdata, port_a_pins, port_a_dir_out, rdata_q, ext_wdata_q, status_q;
    logic [7:0] pointer_q, timer0_count_q, port_a_latch_q, port_b_latch_q;
    logic [10:0] insn_target, pc_q, stack_push_data_q;
    logic [2:0] pc_high_buffer;
    logic [5:0] port_b_pins, port_b_dir_out;
    logic [1:0] ext_page_q;
    logic [8:0] ext_addr_q;
    logic [7:0] rd_exp[$];
    logic [19:0] ext_exp[$];
    logic [2:0] ops[4] = '{3'h4, 3'h1, 3'h2, 3'h3};
    logic [1:0] pex[4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    int error_cnt = 0;
    int checks = 0;

    csfr_bank DUT (.ref_clk(ref_clk), .rst(rst), .main_rd(main_rd), .main_wr(main_wr),
        .config_page_read_insn(config_page_read_insn), .config_page_write_insn(config_page_write_insn),
        .aux_page_read_insn(aux_page_read_insn), .aux_page_write_insn(aux_page_write_insn),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .ext_rdata(ext_rdata), .insn_done(insn_done),
        .long_jump_insn(long_jump_insn), .long_subroutine_insn(long_subroutine_insn),
        .insn_target(insn_target), .pc_high_buffer(pc_high_buffer), .flag_carry_we(flag_carry_we),
        .alu_carry(alu_carry), .flag_half_we(flag_half_we), .alu_half_carry(alu_half_carry),
        .flag_zero_we(flag_zero_we), .alu_zero(alu_zero), .sleep_insn(sleep_insn),
        .watchdog_kick_insn(watchdog_kick_insn), .watchdog_timeout(watchdog_timeout), .inst_tick(inst_tick),
        .timer0_mode_setting(timer0_mode_setting), .timer0_cfg_low_osc(timer0_cfg_low_osc),
        .timer0_external_clock_pin(timer0_external_clock_pin), .low_osc_clk(low_osc_clk),
        .port_a_pins(port_a_pins), .port_a_dir_out(port_a_dir_out), .port_b_pins(port_b_pins),
        .port_b_dir_out(port_b_dir_out), .port_readback_option(port_readback_option), .rdata_q(rdata_q),
        .rd_valid_q(rd_valid_q), .ext_rd_q(ext_rd_q), .ext_wr_q(ext_wr_q), .ext_page_q(ext_page_q),
        .ext_addr_q(ext_addr_q), .ext_wdata_q(ext_wdata_q), .pc_q(pc_q), .stack_push_q(stack_push_q),
        .stack_push_data_q(stack_push_data_q), .status_q(status_q), .pointer_q(pointer_q),
        .timer0_count_q(timer0_count_q), .timer0_overflow_q(timer0_overflow_q),
        .port_a_latch_q(port_a_latch_q), .port_b_latch_q(port_b_latch_q));
    csfr_ext_model partner (.ref_clk(ref_clk), .rst(rst), .ext_rd_q(ext_rd_q), .ext_page_q(ext_page_q),
        .ext_addr_q(ext_addr_q), .ext_rdata(ext_rdata));

    // ==========================================================
    // helpers
    task automatic conclude();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] s);
        checks++;
        if (e !== s) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [7:0] pexp(input logic [7:0] lat, input logic [7:0] pin, input logic [7:0] dir,
                                        input logic opt);
        pexp = (dir & {8{opt}} & lat) | (~(dir & {8{opt}}) & pin);
    endfunction : pexp
    // k: 0 main rd, 1 main wr, 2 config rd, 3 config wr, 4 aux rd, 5 aux wr; a gap cycle follows
    task automatic acc(input logic [2:0] k, input logic [6:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        {aux_page_write_insn, aux_page_read_insn, config_page_write_insn, config_page_read_insn,
            main_wr, main_rd} = 6'h01 << k;
        step();
        {aux_page_write_insn, aux_page_read_insn, config_page_write_insn, config_page_read_insn,
            main_wr, main_rd} = 6'h00;
        step();
    endtask : acc
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        rd_exp.push_back(e);
        acc(3'd0, a, 8'h00);
    endtask : rd
    task automatic ext(input logic [2:0] k, input logic [6:0] a, input logic [7:0] d, input logic [1:0] p,
                       input logic [8:0] ea);
        ext_exp.push_back({k[0], p, ea, k[0] ? d : 8'h00});
        if (!k[0]) rd_exp.push_back(ea[7:0] ^ {p, ea[8], 5'h0c});
        acc(k, a, d);
    endtask : ext

    // ==========================================================
    // monitor: oldest note against each result
    always @(posedge ref_clk) begin
        if (rd_valid_q === 1'b1) begin
            chk("rdata", rd_exp.size() ? rd_exp.pop_front() : 20'hfffff, rdata_q);
        end
        if (ext_rd_q === 1'b1 || ext_wr_q === 1'b1) begin
            chk("ext", ext_exp.size() ? ext_exp.pop_front() : 20'hfffff,
                {ext_wr_q, ext_page_q, ext_addr_q, ext_wr_q ? ext_wdata_q : 8'h00});
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #(40 * 5000);
        error_cnt++;
        $display("MISMATCH watchdog expected done seen hang");
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] d, e;
        logic [10:0] t, u;
        logic [6:0] a;
        int unsigned seed;
        {main_rd, main_wr, config_page_read_insn, config_page_write_insn, aux_page_read_insn,
            aux_page_write_insn, insn_done, long_jump_insn, long_subroutine_insn, flag_carry_we, alu_carry,
            flag_half_we, alu_half_carry, flag_zero_we, alu_zero, sleep_insn, watchdog_kick_insn,
            watchdog_timeout, inst_tick, timer0_mode_setting, timer0_cfg_low_osc, timer0_external_clock_pin,
            low_osc_clk, port_readback_option, cpu_addr, cpu_wdata, insn_target, pc_high_buffer,
            port_a_pins, port_a_dir_out, port_b_pins, port_b_dir_out} = '0;
        rst = 1'b1;
        seed = $urandom(32'h743e);
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("status rst", 8'h18, status_q);
        chk("pc rst", 11'h000, pc_q);
        chk("ptr rst", 8'h00, pointer_q);
        for (int i = 0; i < 4; i++) begin
            {d, e, port_a_pins, port_a_dir_out, port_b_pins, port_b_dir_out} = 44'({$urandom, $urandom});
            port_readback_option = i[0];
            acc(3'd1, 7'h05, d);
            chk("latch a", d, port_a_latch_q);
            acc(3'd1, 7'h06, e);
            chk("latch b", e, port_b_latch_q);
            rd(7'h05, pexp(d, port_a_pins, port_a_dir_out, i[0]));
            rd(7'h06, pexp(e, {e[7:6], port_b_pins}, {2'h0, port_b_dir_out}, i[0]));
        end
        for (int b = 0; b < 4; b++) begin
            acc(3'd1, 7'h03, {b[1:0], 6'h00});
            chk("bank", b[1:0], status_q[7:6]);
            a = 7'h07 + 7'($urandom_range(0, 120));
            ext(3'd0, a, 8'h00, 2'h0, {b[1:0], a});
            a = 7'($urandom_range(0, 6));
            ext(3'd2, a, 8'h00, 2'h1, {2'h0, a});
            ext(3'd3, a, 8'($urandom), 2'h1, {2'h0, a});
            ext(3'd4, a, 8'h00, 2'h2, {2'h0, a});
            ext(3'd5, a, 8'($urandom), 2'h2, {2'h0, a});
        end
        acc(3'd1, 7'h03, 8'ha5);
        rd(7'h03, 8'ha5);
        acc(3'd1, 7'h04, 8'h85);
        chk("ptr", 8'h85, pointer_q);
        acc(3'd1, 7'h00, 8'h3c);
        chk("indirect wr", 8'h3c, port_a_latch_q);
        port_a_dir_out = 8'hff;
        port_readback_option = 1'b1;
        rd(7'h00, 8'h3c);
        acc(3'd1, 7'h04, 8'h80);
        rd(7'h00, 8'h00);
        acc(3'd1, 7'h04, 8'ha0);
        ext(3'd0, 7'h00, 8'h00, 2'h0, 9'h120);
        ext(3'd1, 7'h00, 8'h6e, 2'h0, 9'h120);
        {flag_carry_we, flag_half_we, flag_zero_we} = 3'h7;
        for (int i = 0; i < 8; i++) begin
            {alu_zero, alu_half_carry, alu_carry} = i[2:0];
            step();
            chk("flags", i[2:0], status_q[2:0]);
        end
        {flag_carry_we, flag_half_we, flag_zero_we} = 3'h0;
        {alu_zero, alu_half_carry, alu_carry} = 3'h0;
        step();
        chk("flags held", 3'h7, status_q[2:0]);
        for (int i = 0; i < 4; i++) begin
            {sleep_insn, watchdog_kick_insn, watchdog_timeout} = ops[i];
            step();
            {sleep_insn, watchdog_kick_insn, watchdog_timeout} = 3'h0;
            chk("to pd", pex[i], status_q[4:3]);
            step();
        end
        insn_done = 1'b1;
        repeat (3) step();
        chk("pc step", 11'h003, pc_q);
        t = 11'($urandom);
        {long_jump_insn, insn_target} = {1'b1, t};
        step();
        u = 11'($urandom);
        {long_jump_insn, long_subroutine_insn, insn_target} = {2'b01, u};
        chk("pc jump", t, pc_q);
        step();
        {long_subroutine_insn, insn_done} = 2'b00;
        chk("call pc", u, pc_q);
        chk("call push", {1'b1, t + 11'h001}, {stack_push_q, stack_push_data_q});
        {pc_high_buffer, d} = 11'($urandom);
        acc(3'd1, 7'h02, d);
        chk("pcl wr", {pc_high_buffer, d}, pc_q);
        rd(7'h02, d);
        acc(3'd1, 7'h01, 8'hfd);
        inst_tick = 1'b1;
        repeat (3) step();
        chk("timer0_count wrap", 9'h100, {timer0_overflow_q, timer0_count_q});
        inst_tick = 1'b0;
        rd(7'h01, 8'h00);
        {timer0_mode_setting, timer0_cfg_low_osc, inst_tick} = 3'h7;
        // only the selected slow source toggles and inst_tick stays high, so a wrong select leaves the count other than 5
        for (int i = 0; i < 5; i++) begin
            if (i == 3) timer0_cfg_low_osc = 1'b0;
            {low_osc_clk, timer0_external_clock_pin} = (i < 3) ? 2'h2 : 2'h1;
            repeat (3) step();
            {low_osc_clk, timer0_external_clock_pin} = 2'h0;
            repeat (3) step();
        end
        chk("timer0_count src", 8'h05, timer0_count_q);
        repeat (4) step();
        chk("pending", 20'h0, rd_exp.size() + ext_exp.size());
        conclude();
    end
endmodule : csfr_bank_tb_top

`default_nettype wire

// ===== csfr_ext_model.sv
// outside-register responder for the core register bank's outward accesses
// assumes ext_rdata is sampled by the bank in the same cycle ext_rd_q is high
`timescale 1ns/1ps
`default_nettype none

module csfr_ext_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ext_rd_q,
    input wire logic [1:0] ext_page_q,
    input wire logic [8:0] ext_addr_q,
    output logic [7:0] ext_rdata
);
    // ==========================================================
    // idle pattern
    logic [7:0] junk_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            junk_q <= 8'h00;
        end else begin
            junk_q <= junk_q + 8'h5b;
        end
    end
    // ==========================================================
    // answer
    // outside a read the bus moves every cycle, so a late sample cannot pass by luck
    assign ext_rdata = ext_rd_q ? (ext_addr_q[7:0] ^ {ext_page_q, ext_addr_q[8], 5'h0c}) : junk_q;
endmodule : csfr_ext_model

`default_nettype wire

// ===== csfr_pkg.sv
// core register bank constants: page codes, offsets, field positions, reset values
// assumes one core clock and a single execution core driving the bank
//
// Functional notes
// [R1] config/aux pages reached only by their instructions
// [R2] bank bits ignored for config/aux page targets
// [R3] indirect port accesses register named by pointer
// [R4] timer0 read is live, write replaces count
// [R5] timer0 ticks from instruction, pin or low osc
// [R6] 11-bit pc, low byte at 0x2, increments
// [R7] upper pc bits only via high buffer
// [R8] long jump loads all eleven pc bits
// [R9] long call loads pc, pushes pc plus one
// [R10] carry set on carry or no borrow
// [R11] half carry from low nibble likewise
// [R12] zero flag set when result is zero
// [R13] power-down flag: set power-up/kick, cleared by sleep
// [R14] timeout flag: set power-up/kick/sleep, cleared by timeout
// [R15] two bank bits select bank, reset zero
// [R16] pointer low seven bits select; top bit storage
// [R17] port read: pin, or latch per readback option
// [R18] port a write goes to output latch
// [R19] port b write goes to output latch
// [R20] port b bits 7 and 6 plain storage
// [R21] pcl write loads upper bits from buffer
// [R22] indirect address is bank plus pointer offset
`default_nettype none

package csfr_pkg;
    // =====================================================
    // pages and offsets
    localparam logic [1:0] PAGE_MAIN = 2'h0;
    localparam logic [1:0] PAGE_CONFIG = 2'h1;
    localparam logic [1:0] PAGE_AUX = 2'h2;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_TIMER0 = 7'h01;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PORT_A = 7'h05;
    localparam logic [6:0] OFS_PORT_B = 7'h06;
    localparam logic [6:0] OFS_FIRST_EXT = 7'h07;
    // =====================================================
    // status, pointer and port b field positions
    localparam int STAT_C = 0;
    localparam int STAT_DC = 1;
    localparam int STAT_Z = 2;
    localparam int STAT_PD_N = 3;
    localparam int STAT_TO_N = 4;
    localparam int STAT_BANK_HI = 7;
    localparam int STAT_BANK_LO = 6;
    localparam int PTR_SPARE = 7;
    localparam int PORT_B_DATA_PINS = 6;
    // =====================================================
    // reset values, pc step and timer0 mode code
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] TIMER0_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [10:0] PC_STEP = 11'h001;
    localparam logic TIMER0_MODE_INST = 1'b0;
endpackage : csfr_pkg

`default_nettype wire
